// >>> cdbc_top.sv
// card presence detection and boot controller top level
`timescale 1ns/1ps
`default_nettype none

module cdbc_top (
    input  wire logic        ref_clk,           // 250 MHz clock
    input  wire logic        resetn,            // async reset, active low
    input  wire logic        debounce_clk_ok,   // debounce clock is valid
    input  wire logic        card_present_n,    // card detect pin, low = card
    input  wire logic        xdomain_toggle,    // toggle from another domain
    output var  logic        xdomain_pulse,     // one pulse per toggle edge
    output var  logic        card_present,      // debounced presence
    output var  logic        card_insert_evt,   // insertion event pulse
    output var  logic        card_remove_evt,   // removal event pulse
    output var  logic        card_init_req,     // run init for probe type
    output var  logic [1:0]  card_init_type,    // interface type being probed
    input  wire logic        card_init_done,    // init succeeded, pulse
    input  wire logic        card_init_fail,    // init failed, pulse
    output var  logic        sector_rd_req,     // read sector request
    output var  logic [1:0]  sector_index,      // sector being read
    input  wire logic        card_byte_valid,   // read byte strobe
    input  wire logic [7:0]  card_byte,         // read byte
    output var  logic        cpu_reset_n,       // processor reset, low = held
    input  wire logic        boot_cs_n,         // boot chip select, active low
    input  wire logic [8:0]  boot_addr,         // word address
    output var  logic [31:0] boot_rdata,        // read data
    output var  logic        boot_ready,        // access may complete
    input  wire logic        boot_release,      // loader done, leave boot mode
    output var  logic        boot_done          // boot window closed
);

    // ****************************************************************
    // synchronisers
    // ****************************************************************
    logic cd_n_sync;

    cdbc_sync u_cd_sync (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .async_in  (card_present_n),
        .sync_out  (cd_n_sync),
        .pulse_out ()
    );

    cdbc_sync u_tog_sync (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .async_in  (xdomain_toggle),
        .sync_out  (),
        .pulse_out (xdomain_pulse)
    );

    // ****************************************************************
    // card presence state machine
    // ****************************************************************
    cdbc_pkg::cdbc_cd_state_t cd_state;
    cdbc_pkg::cdbc_cd_state_t next_cd_state;
    logic [8:0]               stable_cnt;
    logic                     cd_prev;
    logic                     stable_done;

    // more than 256 clocks: counter at 256 and still unchanged
    assign stable_done = (stable_cnt == cdbc_pkg::DEBOUNCE_STABLE_CLKS) && (cd_n_sync == cd_prev);

    always_comb
    begin
        next_cd_state = cd_state;
        case (cd_state)
            cdbc_pkg::CDBC_CD_RESET:
                if (debounce_clk_ok)
                    next_cd_state = cdbc_pkg::CDBC_CD_DEBOUNCE;
            cdbc_pkg::CDBC_CD_DEBOUNCE:
                if (stable_done)
                    next_cd_state = cd_n_sync ? cdbc_pkg::CDBC_CD_NOCARD : cdbc_pkg::CDBC_CD_INSERTED;
            cdbc_pkg::CDBC_CD_INSERTED:
                if (cd_n_sync)
                    next_cd_state = cdbc_pkg::CDBC_CD_DEBOUNCE;
            cdbc_pkg::CDBC_CD_NOCARD:
                if (!cd_n_sync)
                    next_cd_state = cdbc_pkg::CDBC_CD_DEBOUNCE;
            default:
                next_cd_state = cdbc_pkg::CDBC_CD_RESET;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            cd_state <= cdbc_pkg::CDBC_CD_RESET;
        else
            cd_state <= next_cd_state;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cd_prev    <= 1'b1;
            stable_cnt <= cdbc_pkg::DEBOUNCE_CNT_RESET;
        end
        else
        begin
            cd_prev <= cd_n_sync;
            if (cd_state != cdbc_pkg::CDBC_CD_DEBOUNCE || cd_n_sync != cd_prev)
                stable_cnt <= cdbc_pkg::DEBOUNCE_CNT_RESET;
            else if (stable_cnt != cdbc_pkg::DEBOUNCE_STABLE_CLKS)
                stable_cnt <= stable_cnt + 9'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            card_present    <= 1'b0;
            card_insert_evt <= 1'b0;
            card_remove_evt <= 1'b0;
        end
        else
        begin
            card_present    <= (next_cd_state == cdbc_pkg::CDBC_CD_INSERTED);
            card_insert_evt <= (cd_state != cdbc_pkg::CDBC_CD_INSERTED)
                               && (next_cd_state == cdbc_pkg::CDBC_CD_INSERTED);
            card_remove_evt <= (cd_state == cdbc_pkg::CDBC_CD_INSERTED)
                               && (next_cd_state != cdbc_pkg::CDBC_CD_INSERTED);
        end
    end

    // ****************************************************************
    // boot sequencer
    // ****************************************************************
    cdbc_pkg::cdbc_boot_state_t bt_state;
    logic [10:0]                byte_cnt;
    logic [23:0]                word_acc;
    logic [31:0]                boot_ram [cdbc_pkg::BOOT_RAM_WORDS];
    logic                       card_lost;
    logic                       last_byte;
    logic                       access_open;

    assign card_lost = (cd_state != cdbc_pkg::CDBC_CD_INSERTED);
    assign last_byte = card_byte_valid && (byte_cnt == cdbc_pkg::BOOT_LAST_BYTE);

    // probe, init, then copy four sectors
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bt_state       <= cdbc_pkg::CDBC_BT_WAIT;
            card_init_req  <= 1'b0;
            card_init_type <= cdbc_pkg::CDBC_TYPE_SD;
            sector_rd_req  <= 1'b0;
            byte_cnt       <= cdbc_pkg::BOOT_BYTE_RESET;
        end
        else
        begin
            case (bt_state)
                cdbc_pkg::CDBC_BT_WAIT:
                    if (!card_lost)
                    begin
                        bt_state       <= cdbc_pkg::CDBC_BT_INIT;
                        card_init_req  <= 1'b1;
                        card_init_type <= cdbc_pkg::CDBC_TYPE_SD;
                    end
                cdbc_pkg::CDBC_BT_INIT:
                    if (card_lost)
                    begin
                        bt_state      <= cdbc_pkg::CDBC_BT_WAIT;
                        card_init_req <= 1'b0;
                    end
                    else if (card_init_done)
                    begin
                        bt_state      <= cdbc_pkg::CDBC_BT_LOAD;
                        card_init_req <= 1'b0;
                        sector_rd_req <= 1'b1;
                        byte_cnt      <= cdbc_pkg::BOOT_BYTE_RESET;
                    end
                    else if (card_init_fail)
                        // wraps back to SD after the last type
                        card_init_type <= card_init_type + 2'h1;
                cdbc_pkg::CDBC_BT_LOAD:
                    if (card_lost)
                    begin
                        bt_state      <= cdbc_pkg::CDBC_BT_WAIT;
                        sector_rd_req <= 1'b0;
                    end
                    else if (card_byte_valid)
                    begin
                        byte_cnt <= byte_cnt + 11'h001;
                        if (last_byte)
                        begin
                            bt_state      <= cdbc_pkg::CDBC_BT_SERVE;
                            sector_rd_req <= 1'b0;
                        end
                    end
                cdbc_pkg::CDBC_BT_SERVE:
                    if (boot_release && boot_cs_n)
                        bt_state <= cdbc_pkg::CDBC_BT_DONE;
                cdbc_pkg::CDBC_BT_DONE:
                    bt_state <= cdbc_pkg::CDBC_BT_DONE;
                default:
                    bt_state <= cdbc_pkg::CDBC_BT_WAIT;
            endcase
        end
    end

    always_comb
        sector_index = byte_cnt[10:9];

    // bytes packed little-endian; the ram has no reset, its content is loaded
    always_ff @(posedge ref_clk)
    begin
        if (bt_state == cdbc_pkg::CDBC_BT_LOAD && card_byte_valid)
        begin
            if (byte_cnt[1:0] == 2'h3)
                boot_ram[byte_cnt[10:2]] <= {card_byte, word_acc};
            else
                word_acc <= {card_byte, word_acc[23:8]};
        end
    end

    // processor leaves reset only once serving
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpu_reset_n <= 1'b0;
            boot_done   <= 1'b0;
        end
        else
        begin
            cpu_reset_n <= (bt_state == cdbc_pkg::CDBC_BT_SERVE) || (bt_state == cdbc_pkg::CDBC_BT_DONE);
            boot_done   <= (bt_state == cdbc_pkg::CDBC_BT_DONE);
        end
    end

    // ready gates each chip select access; one wait cycle for the ram read
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            access_open <= 1'b0;
            boot_ready  <= 1'b0;
            boot_rdata  <= cdbc_pkg::BOOT_RDATA_RESET;
        end
        else
        begin
            if (boot_cs_n || bt_state != cdbc_pkg::CDBC_BT_SERVE)
            begin
                access_open <= 1'b0;
                boot_ready  <= 1'b0;
            end
            else if (!access_open)
            begin
                access_open <= 1'b1;
                boot_rdata  <= boot_ram[boot_addr];
                boot_ready  <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> cdbc_pkg.sv
// constants and types shared by the card detect and boot controller
package cdbc_pkg;

    // ****************************************************************
    // card presence debouncing
    // ****************************************************************
    localparam logic [8:0]  DEBOUNCE_STABLE_CLKS = 9'h100;   // 256 clocks
    localparam logic [8:0]  DEBOUNCE_CNT_RESET   = 9'h000;

    typedef enum logic [3:0] {
        CDBC_CD_RESET    = 4'h1,
        CDBC_CD_DEBOUNCE = 4'h2,
        CDBC_CD_INSERTED = 4'h4,
        CDBC_CD_NOCARD   = 4'h8
    } cdbc_cd_state_t;

    // ****************************************************************
    // boot loader storage
    // ****************************************************************
    localparam int          BOOT_RAM_BYTES    = 2048;
    localparam int          BOOT_RAM_WORDS    = BOOT_RAM_BYTES / 4;
    localparam int          BOOT_WADDR_W      = 9;
    localparam logic [1:0]  BOOT_LAST_SECTOR  = 2'h3;        // four sectors
    localparam logic [10:0] BOOT_LAST_BYTE    = 11'h7FF;
    localparam logic [10:0] BOOT_BYTE_RESET   = 11'h000;

    // card interface types, probed in this order
    typedef enum logic [1:0] {
        CDBC_TYPE_SD   = 2'h0,
        CDBC_TYPE_SDHC = 2'h1,
        CDBC_TYPE_MMC  = 2'h2,
        CDBC_TYPE_NAND = 2'h3
    } cdbc_card_type_t;

    typedef enum logic [4:0] {
        CDBC_BT_WAIT  = 5'h01,
        CDBC_BT_INIT  = 5'h02,
        CDBC_BT_LOAD  = 5'h04,
        CDBC_BT_SERVE = 5'h08,
        CDBC_BT_DONE  = 5'h10
    } cdbc_boot_state_t;

    localparam logic [31:0] BOOT_RDATA_RESET = 32'h0000_0000;

endpackage

// >>> cdbc_sync.sv
// two-stage synchroniser with registered toggle-to-pulse output
`timescale 1ns/1ps
`default_nettype none

module cdbc_sync (
    input  wire logic ref_clk,    // destination clock
    input  wire logic resetn,     // async reset, active low
    input  wire logic async_in,   // level or toggle from another domain
    output var  logic sync_out,   // synchronised level
    output var  logic pulse_out   // one cycle per level change
);

    logic meta;
    logic prev;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prev      <= 1'b0;
            pulse_out <= 1'b0;
        end
        else
        begin
            prev      <= sync_out;
            pulse_out <= sync_out ^ prev;
        end
    end

endmodule

`default_nettype wire

// >>> cdbc_checker.sv
// port assertions for the card detect and boot controller
`timescale 1ns/1ps
`default_nettype none

module cdbc_checker (
    input wire logic       ref_clk,         // clock
    input wire logic       resetn,          // reset
    input wire logic       card_present_n,  // pin
    input wire logic       xdomain_toggle,  // toggle in
    input wire logic       xdomain_pulse,   // pulse out
    input wire logic       card_present,    // presence
    input wire logic       card_insert_evt, // insert event
    input wire logic       card_remove_evt, // remove event
    input wire logic       card_init_req,   // init request
    input wire logic [1:0] card_init_type,  // probe type
    input wire logic       card_init_fail,  // init fail
    input wire logic       sector_rd_req,   // copy request
    input wire logic       card_byte_valid, // byte strobe
    input wire logic       cpu_reset_n,     // cpu reset
    input wire logic       boot_cs_n,       // chip select
    input wire logic       boot_ready       // ready
);
    // ****************************************
    // helper counters
    // ****************************************
    logic [11:0] low_run; // samples with the pin low
    logic [11:0] n_bytes; // bytes taken since the last init

    always_ff @(posedge ref_clk or negedge resetn)
        if (!resetn)
            low_run <= 12'h000;
        else
            low_run <= card_present_n ? 12'h000 : low_run + {11'h000, low_run != 12'hFFF};

    // a new init restarts the copy, so the count follows it
    always_ff @(posedge ref_clk or negedge resetn)
        if (!resetn)
            n_bytes <= 12'h000;
        else
            n_bytes <= card_init_req ? 12'h000 : n_bytes + {11'h000, sector_rd_req & card_byte_valid};

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_ready_drop; boot_cs_n [*2] |-> !boot_ready; endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready held without select");
    property p_ready_cause; $rose(boot_ready) |-> $past(boot_cs_n) == 1'b0; endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without select");
    property p_hold_cpu; (sector_rd_req || card_init_req) |-> !cpu_reset_n; endproperty
    a_hold_cpu: assert property (p_hold_cpu) else $error("cpu released while loading");
    property p_copy_full; $rose(cpu_reset_n) |-> n_bytes == 12'h800; endproperty
    a_copy_full: assert property (p_copy_full) else $error("cpu released before full copy");
    property p_pulse_one; xdomain_pulse |=> !xdomain_pulse; endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("pulse longer than one cycle");
    property p_pulse_cause; xdomain_pulse |-> $past(xdomain_toggle, 3) != $past(xdomain_toggle, 4)
        || $past(xdomain_toggle, 4) != $past(xdomain_toggle, 5); endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without toggle");
    property p_remove_fast; card_present_n [*5] |-> !card_present; endproperty
    a_remove_fast: assert property (p_remove_fast) else $error("presence kept after removal");
    property p_insert_stable; $rose(card_present) |-> low_run >= 12'h101; endproperty
    a_insert_stable: assert property (p_insert_stable) else $error("insert before stable period");
    property p_insert_evt; $rose(card_present) |-> ##[0:1] card_insert_evt; endproperty
    a_insert_evt: assert property (p_insert_evt) else $error("no insert event");
    property p_remove_evt; $fell(card_present) |-> ##[0:1] card_remove_evt; endproperty
    a_remove_evt: assert property (p_remove_evt) else $error("no remove event");
    property p_type_next; card_init_req && card_init_fail |=> card_init_type == $past(card_init_type) + 2'h1;
    endproperty
    a_type_next: assert property (p_type_next) else $error("probe type not advanced");
endmodule

bind cdbc_top cdbc_checker cdbc_checker_i (
    .ref_clk, .resetn, .card_present_n, .xdomain_toggle, .xdomain_pulse, .card_present, .card_insert_evt,
    .card_remove_evt, .card_init_req, .card_init_type, .card_init_fail, .sector_rd_req, .card_byte_valid,
    .cpu_reset_n, .boot_cs_n, .boot_ready
);

`default_nettype wire

// >>> cdbc_card_model.sv
// card side model: probe answers and boot sector byte stream
`timescale 1ns/1ps
`default_nettype none

module cdbc_card_model #(
    parameter logic [1:0] GOOD_TYPE = 2'h3  // first type that initialises
) (
    input  wire logic       ref_clk,         // clock
    input  wire logic       resetn,          // reset
    input  wire logic       card_init_req,   // init request
    input  wire logic [1:0] card_init_type,  // type probed
    input  wire logic       sector_rd_req,   // copy request
    output var  logic       card_init_done,  // init ok pulse
    output var  logic       card_init_fail,  // init fail pulse
    output var  logic       card_byte_valid, // byte strobe
    output var  logic [7:0] card_byte        // byte data
);
    logic [2:0]  wait_cnt;
    logic [1:0]  last_type;
    logic [11:0] idx;
    logic        ph;
    logic        go;

    // a byte is offered next cycle
    assign go = !card_init_req && sector_rd_req && idx != 12'h800 && !(idx[6] && ph);

    always_ff @(posedge ref_clk or negedge resetn)
        if (!resetn)
            {wait_cnt, last_type, card_init_done, card_init_fail} <= 7'h00;
        else
        begin
            last_type <= card_init_type;
            wait_cnt <= (!card_init_req || card_init_type != last_type) ? 3'h0 : wait_cnt + {2'h0, wait_cnt != 3'h7};
            card_init_done <= card_init_req && wait_cnt == 3'h3 && card_init_type == GOOD_TYPE;
            card_init_fail <= card_init_req && wait_cnt == 3'h3 && card_init_type != GOOD_TYPE;
        end

    // bytes in order; stalls on alternate cycles in some stretches, idle data inverted
    always_ff @(posedge ref_clk or negedge resetn)
        if (!resetn)
            {idx, ph, card_byte_valid, card_byte} <= 22'h000000;
        else
        begin
            ph <= ~ph;
            card_byte_valid <= go;
            card_byte <= go ? idx[7:0] ^ {idx[10:8], 5'h00} : ~card_byte;
            if (card_init_req)
                idx <= 12'h000;
            else if (go)
                idx <= idx + 12'h001;
        end
endmodule

`default_nettype wire

// >>> testbench.sv
// self-checking bench for the card detect and boot controller
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        ref_clk = 1'b0, resetn = 1'b0, debounce_clk_ok = 1'b0, card_present_n = 1'b1;
    logic        xdomain_toggle = 1'b0, boot_cs_n = 1'b1, boot_release = 1'b0;
    logic [8:0]  boot_addr = 9'h000;
    logic        xdomain_pulse, card_present, card_insert_evt, card_remove_evt, card_init_req, card_init_done;
    logic        card_init_fail, sector_rd_req, card_byte_valid, cpu_reset_n, boot_ready, boot_done;
    logic [1:0]  card_init_type, sector_index;
    logic [10:0] n_byt = 11'h000;
    logic [7:0]  card_byte;
    logic [31:0] boot_rdata;
    int          n_mismatch = 0, comparisons = 0, n_ins = 0, n_rem = 0, n_pul = 0, i;

    cdbc_top cdbc_top_i (
        .ref_clk, .resetn, .debounce_clk_ok, .card_present_n, .xdomain_toggle, .xdomain_pulse, .card_present,
        .card_insert_evt, .card_remove_evt, .card_init_req, .card_init_type, .card_init_done, .card_init_fail,
        .sector_rd_req, .sector_index, .card_byte_valid, .card_byte, .cpu_reset_n, .boot_cs_n, .boot_addr,
        .boot_rdata, .boot_ready, .boot_release, .boot_done
    );
    cdbc_card_model cdbc_card_model_i (
        .ref_clk, .resetn, .card_init_req, .card_init_type, .sector_rd_req, .card_init_done, .card_init_fail,
        .card_byte_valid, .card_byte
    );

    always #2 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        n_ins <= n_ins + (card_insert_evt === 1'b1);
        n_rem <= n_rem + (card_remove_evt === 1'b1);
        n_pul <= n_pul + (xdomain_pulse === 1'b1);
        n_byt <= card_init_req ? 11'h000 : n_byt + {10'h000, sector_rd_req & card_byte_valid};
    end

    // ****************************************
    // shared tasks
    // ****************************************
    function automatic logic [7:0] pat(input logic [10:0] k);
        return k[7:0] ^ {k[10:8], 5'h00};
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hang(input string what);
        n_mismatch++;
        $display("[ERR] %s expected event seen timeout", what);
        final_report();
    endtask

    // inputs always change 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input logic [8:0] a);
        boot_cs_n = 1'b0;
        boot_addr = a;
        for (i = 0; i < 8 && boot_ready !== 1'b1; i++) cyc(1);
        if (boot_ready !== 1'b1) hang("boot ready");
        // hold the select across the edge that samples ready high
        cyc(1);
        chk("boot word", {pat({a, 2'h3}), pat({a, 2'h2}), pat({a, 2'h1}), pat({a, 2'h0})}, boot_rdata);
        boot_cs_n = 1'b1;
        cyc(2);
        chk("ready after select", 32'h0, {31'h0, boot_ready});
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_detect();
        card_present_n = 1'b0;
        cyc(300);
        chk("present without clock", 32'h0, {31'h0, card_present});
        debounce_clk_ok = 1'b1;
        card_present_n = 1'b1;
        cyc(300);
        chk("present with pin high", 32'h0, {31'h0, card_present});
        card_present_n = 1'b0;
        cyc(200);
        card_present_n = 1'b1;
        cyc(3);
        card_present_n = 1'b0;
        cyc(250);
        chk("present after glitch", 32'h0, {31'h0, card_present});
        for (i = 0; i < 30 && card_present !== 1'b1; i++) cyc(1);
        chk("present stable low", 32'h1, {31'h0, card_present});
        cyc(2);
        chk("insert events", 32'h1, n_ins);
        $display("t_detect done");
    endtask

    task automatic t_abort();
        for (i = 0; i < 200 && sector_rd_req !== 1'b1; i++) cyc(1);
        if (sector_rd_req !== 1'b1) hang("copy start");
        chk("probe type", 32'h3, {30'h0, card_init_type});
        boot_cs_n = 1'b0;
        cyc(10);
        chk("ready while copying", 32'h0, {31'h0, boot_ready});
        boot_cs_n = 1'b1;
        card_present_n = 1'b1;
        cyc(6);
        chk("present after removal", 32'h0, {31'h0, card_present});
        chk("copy after removal", 32'h0, {31'h0, sector_rd_req});
        chk("remove events", 32'h1, n_rem);
        chk("cpu held", 32'h0, {31'h0, cpu_reset_n});
        card_present_n = 1'b0;
        $display("t_abort done");
    endtask

    task automatic t_boot();
        logic [8:0] adr [4] = '{9'h000, 9'h001, 9'h0FF, 9'h1FF};
        for (i = 0; i < 9000 && cpu_reset_n !== 1'b1; i++)
        begin
            cyc(1);
            if (sector_rd_req === 1'b1) chk("sector index", {30'h0, n_byt[10:9]}, {30'h0, sector_index});
        end
        if (cpu_reset_n !== 1'b1) hang("cpu release");
        chk("insert events", 32'h2, n_ins);
        foreach (adr[k]) rd(adr[k]);
        boot_release = 1'b1;
        cyc(3);
        chk("boot done", 32'h1, {31'h0, boot_done});
        $display("t_boot done");
    endtask

    task automatic t_toggle();
        int s;
        s = n_pul;
        repeat (5)
        begin
            xdomain_toggle = ~xdomain_toggle;
            cyc(7);
        end
        chk("toggle pulses", 32'h5, n_pul - s);
        $display("t_toggle done");
    endtask

    initial
    begin
        cyc(20);
        resetn = 1'b1;
        t_detect();
        t_abort();
        t_boot();
        t_toggle();
        final_report();
    end
endmodule

`default_nettype wire
